// *** design/cfg_bank_pkg.sv ***
package cfg_bank_pkg;

	// ==========================================================
	// serial address map
	localparam logic [5:0] ADDR_PIN2_CFG     = 6'h00;
	localparam logic [5:0] ADDR_PIN1_CFG     = 6'h01;
	localparam logic [5:0] ADDR_PIN0_CFG     = 6'h02;
	localparam logic [5:0] ADDR_THR_CFG      = 6'h03;
	localparam logic [5:0] ADDR_STROBE_FIRST = 6'h30;
	localparam logic [5:0] ADDR_STROBE_LAST  = 6'h3D;
	localparam logic [5:0] ADDR_FIFO         = 6'h3F;

	// ==========================================================
	// header byte fields
	localparam int HDR_READ_BIT  = 7;
	localparam int HDR_BURST_BIT = 6;

	// ==========================================================
	// field positions
	localparam int PIN_INVERT_BIT     = 6;
	localparam int PIN_DRIVE_BIT      = 7;
	localparam int TEMP_SENSOR_BIT    = 7;
	localparam int RETENTION_BIT      = 6;
	localparam int ATTEN_LSB          = 4;
	localparam int SELECT_W           = 6;

	// ==========================================================
	// reset values
	localparam logic [7:0] PIN2_CFG_RESET = 8'h29;
	localparam logic [7:0] PIN1_CFG_RESET = 8'h2E;
	localparam logic [7:0] PIN0_CFG_RESET = 8'h3F;
	localparam logic [7:0] THR_CFG_RESET  = 8'h07;
	localparam logic [5:0] SELECT_HIGH_Z  = 6'h2E;

	// ==========================================================
	// test register loads on wake
	localparam logic [7:0] TEST_ONE_PLAIN    = 8'h31;
	localparam logic [7:0] TEST_TWO_PLAIN    = 8'h88;
	localparam logic [7:0] TEST_ONE_RETAINED = 8'h35;
	localparam logic [7:0] TEST_TWO_RETAINED = 8'h81;

	// ==========================================================
	// access sequencer states
	typedef enum logic [2:0]
	{
		ST_HEADER = 3'b001,
		ST_FETCH  = 3'b010,
		ST_DATA   = 3'b100
	} access_state_e;

endpackage : cfg_bank_pkg

// *** design/spi_byte_if.sv ***
// ==========================================================
// byte-level link between the serial shifter and the bank
interface spi_byte_if;
	logic       byte_valid;  // one-cycle pulse per received byte
	logic [7:0] rx_byte;     // byte just received
	logic       frame_act;   // chip select asserted
	logic [7:0] tx_byte;     // next byte to shift out
	logic       miso_bit;    // current serial output bit
	logic       miso_oe_n;   // low while driving serial output

	modport engine (output byte_valid, rx_byte, frame_act, miso_bit, miso_oe_n, input tx_byte);
	modport bank   (input byte_valid, rx_byte, frame_act, miso_bit, miso_oe_n, output tx_byte);
endinterface : spi_byte_if

// *** design/spi_byte_engine.sv ***
module spi_byte_engine
	import cfg_bank_pkg::*;
#(
	parameter int BYTE_W = 8
)
(
	input  wire logic i_ref_clk,   // system clock
	input  wire logic i_rst,       // sync reset, active high
	input  wire logic i_spi_sclk,  // serial clock, sampled
	input  wire logic i_spi_cs_n,  // chip select, active low
	input  wire logic i_spi_mosi,  // serial data in
	spi_byte_if.engine link        // byte side
);

	// ==========================================================
	// elaboration check
	if (BYTE_W != 8)
	begin : g_bad_width
		$error("spi_byte_engine supports only 8-bit bytes");
	end

	logic              sclk_prev_reg;
	logic              cs_n_reg;
	logic [BYTE_W-1:0] shift_in_reg;
	logic [2:0]        bit_cnt_reg;
	logic              byte_valid_reg;
	logic [BYTE_W-1:0] rx_byte_reg;
	logic [BYTE_W-1:0] tx_shift_reg;
	logic              load_pend_reg;
	logic              rise;
	logic              fall;

	assign rise = i_spi_sclk & ~sclk_prev_reg & ~i_spi_cs_n;
	assign fall = ~i_spi_sclk & sclk_prev_reg & ~i_spi_cs_n;

	// edge history and select
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			sclk_prev_reg <= 1'b0;
			cs_n_reg      <= 1'b1;
		end
		else
		begin
			sclk_prev_reg <= i_spi_sclk;
			cs_n_reg      <= i_spi_cs_n;
		end
	end

	// receive: sample on rising serial edge, msb first
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst || i_spi_cs_n)
		begin
			shift_in_reg   <= '0;
			bit_cnt_reg    <= 3'h0;
			byte_valid_reg <= 1'b0;
			rx_byte_reg    <= '0;
		end
		else
		begin
			byte_valid_reg <= rise && (bit_cnt_reg == 3'h7);
			if (rise)
			begin
				shift_in_reg <= {shift_in_reg[BYTE_W-2:0], i_spi_mosi};
				bit_cnt_reg  <= bit_cnt_reg + 3'h1;
				if (bit_cnt_reg == 3'h7)
					rx_byte_reg <= {shift_in_reg[BYTE_W-2:0], i_spi_mosi};
			end
		end
	end

	// transmit: change on falling edge; a new byte is taken at the
	// first fall after a byte ends, so the bank has a few cycles
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			tx_shift_reg  <= '0;
			load_pend_reg <= 1'b0;
		end
		else if (i_spi_cs_n)
		begin
			tx_shift_reg  <= link.tx_byte;
			load_pend_reg <= 1'b0;
		end
		else
		begin
			if (fall)
			begin
				if (load_pend_reg)
					tx_shift_reg <= link.tx_byte;
				else
					tx_shift_reg <= {tx_shift_reg[BYTE_W-2:0], 1'b0};
			end
			if (byte_valid_reg)
				load_pend_reg <= 1'b1;
			else if (fall)
				load_pend_reg <= 1'b0;
		end
	end

	assign link.byte_valid = byte_valid_reg;
	assign link.rx_byte    = rx_byte_reg;
	assign link.frame_act  = ~cs_n_reg;
	assign link.miso_bit   = tx_shift_reg[BYTE_W-1];
	assign link.miso_oe_n  = cs_n_reg;

endmodule : spi_byte_engine

// *** design/pin_signal_config_bank.sv ***
// Contract
// [R01] each output pin drives its selected signal inverted when its invert bit is set
// [R02] pin-2 select field resets to 0x29, the active-low chip-ready signal
// [R03] pin-1 select field resets to 0x2E, leaving that pin high impedance
// [R04] pin-0 select field resets to 0x3F, the crystal clock divided by 192
// [R05] pin-1 bit 7 sets high or low drive strength for all three pins
// [R06] pin-0 bit 7 enables temperature sensor; host keeps other bits zero then
// [R07] host should turn off the default pin-0 clock output during setup
// [R08] addresses 0x30 to 0x3D are strobes on write, status on read
// [R09] configuration contents are kept through sleep
// [R10] wake loads test registers 0x31/0x88, or 0x35/0x81 with retention set
// [R11] host writes zero to reserved threshold register bits
// [R12] receive attenuation field bits 5:4 resets to zero, 0dB
// [R13] pin-2 bit 7 reads zero and ignores writes
// [R14] header decides read or write; 0x3F reaches transmit or receive FIFO
module pin_signal_config_bank
(
	input  wire logic        i_ref_clk,       // system clock, 100 MHz
	input  wire logic        i_rst,           // sync reset, active high
	input  wire logic        i_spi_sclk,      // serial clock
	input  wire logic        i_spi_cs_n,      // serial chip select
	input  wire logic        i_spi_mosi,      // serial data in
	output logic             o_spi_miso,      // serial data out
	output logic             o_spi_miso_oe_n, // low while driving
	input  wire logic [7:0]  i_chip_status,   // status byte sent during header
	input  wire logic [63:0] i_sig_table,     // internal signals by select code
	input  wire logic        i_wake,          // pulse: leaving sleep
	input  wire logic [7:0]  i_ext_rd_data,   // status or fifo read data
	output logic             o_ext_rd,        // pulse: status or fifo read
	output logic [5:0]       o_ext_rd_addr,   // address of that read
	output logic             o_strobe,        // pulse: command strobe
	output logic [5:0]       o_strobe_addr,   // strobe address
	output logic             o_txfifo_wr,     // pulse: transmit fifo write
	output logic [7:0]       o_txfifo_data,   // transmit fifo byte
	output logic [2:0]       o_pin_out,       // pins 2..0 level
	output logic [2:0]       o_pin_oe_n,      // pins 2..0 enable, low drives
	output logic             o_pin_drive_strong, // high drive strength
	output logic             o_temp_sensor_en,   // temperature sensor on
	output logic [1:0]       o_rx_atten,      // receive attenuation code
	output logic [3:0]       o_fifo_threshold, // fifo threshold code
	output logic [7:0]       o_test_reg_one,  // first test register
	output logic [7:0]       o_test_reg_two   // second test register
);
	import cfg_bank_pkg::*;

	// ==========================================================
	// helpers
	function automatic logic in_strobe_range(input logic [5:0] a);
		return (a >= ADDR_STROBE_FIRST) && (a <= ADDR_STROBE_LAST);
	endfunction : in_strobe_range

	function automatic logic is_external(input logic [5:0] a);
		return in_strobe_range(a) || (a == ADDR_FIFO);
	endfunction : is_external

	// selected signal through the invert bit
	function automatic logic pin_level(input logic [7:0] cfg, input logic [63:0] tbl);
		return tbl[cfg[SELECT_W-1:0]] ^ cfg[PIN_INVERT_BIT];
	endfunction : pin_level

	// ==========================================================
	// serial shifter
	spi_byte_if link ();

	spi_byte_engine #(.BYTE_W(8)) u_engine
	(
		.i_ref_clk  (i_ref_clk),
		.i_rst      (i_rst),
		.i_spi_sclk (i_spi_sclk),
		.i_spi_cs_n (i_spi_cs_n),
		.i_spi_mosi (i_spi_mosi),
		.link       (link)
	);

	// ==========================================================
	// state
	access_state_e state_reg;
	logic          read_reg;
	logic          burst_reg;
	logic [5:0]    addr_reg;
	logic [7:0]    tx_byte_reg;
	logic [6:0]    pin2_cfg_reg;
	logic [7:0]    pin1_cfg_reg;
	logic [7:0]    pin0_cfg_reg;
	logic [7:0]    thr_cfg_reg;
	logic          hdr_byte;
	logic          data_byte;
	logic          cfg_wr;
	logic [7:0]    cfg_rd_data;
	logic [5:0]    addr_next;

	assign hdr_byte  = link.byte_valid && (state_reg == ST_HEADER);
	assign data_byte = link.byte_valid && (state_reg == ST_DATA);
	assign cfg_wr    = data_byte && !read_reg;
	assign addr_next = (addr_reg == ADDR_FIFO) ? addr_reg : addr_reg + 6'h01;
	assign link.tx_byte = tx_byte_reg;

	// config read mux; pin-2 bit 7 always reads zero
	always_comb
	begin
		unique case (addr_reg)
			ADDR_PIN2_CFG: cfg_rd_data = {1'b0, pin2_cfg_reg}; // [R13]
			ADDR_PIN1_CFG: cfg_rd_data = pin1_cfg_reg;
			ADDR_PIN0_CFG: cfg_rd_data = pin0_cfg_reg;
			ADDR_THR_CFG:  cfg_rd_data = thr_cfg_reg;
			default:       cfg_rd_data = 8'h00;
		endcase
	end

	// ==========================================================
	// access sequencer: header, optional fetch, data bytes
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst || !link.frame_act)
		begin
			state_reg <= ST_HEADER;
			read_reg  <= 1'b0;
			burst_reg <= 1'b0;
			addr_reg  <= 6'h00;
		end
		else
		begin
			unique case (state_reg)
				ST_HEADER:
					if (link.byte_valid)
					begin
						read_reg  <= link.rx_byte[HDR_READ_BIT]; // [R14]
						burst_reg <= link.rx_byte[HDR_BURST_BIT];
						addr_reg  <= link.rx_byte[5:0];
						if (link.rx_byte[HDR_READ_BIT])
							state_reg <= ST_FETCH;
						else if (!in_strobe_range(link.rx_byte[5:0]))
							state_reg <= ST_DATA; // a strobe is a lone header
					end
				ST_FETCH:
					state_reg <= ST_DATA;
				ST_DATA:
					if (link.byte_valid)
					begin
						// status reads do not continue in a burst
						if (burst_reg && !in_strobe_range(addr_reg))
						begin
							addr_reg  <= addr_next;
							state_reg <= read_reg ? ST_FETCH : ST_DATA;
						end
						else
							state_reg <= ST_HEADER;
					end
			endcase
		end
	end

	// answer byte: chip status during header, data after fetch
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			tx_byte_reg <= 8'h00;
		else if (state_reg == ST_HEADER)
			tx_byte_reg <= i_chip_status;
		else if (state_reg == ST_FETCH)
			tx_byte_reg <= is_external(addr_reg) ? i_ext_rd_data : cfg_rd_data; // [R08] [R14]
	end

	// ==========================================================
	// external pulses: strobes, status and fifo traffic
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			o_strobe      <= 1'b0;
			o_strobe_addr <= 6'h00;
			o_ext_rd      <= 1'b0;
			o_ext_rd_addr <= 6'h00;
			o_txfifo_wr   <= 1'b0;
			o_txfifo_data <= 8'h00;
		end
		else
		begin
			o_strobe    <= hdr_byte && !link.rx_byte[HDR_READ_BIT]
				&& in_strobe_range(link.rx_byte[5:0]); // [R08]
			o_ext_rd    <= hdr_byte && link.rx_byte[HDR_READ_BIT]
				&& is_external(link.rx_byte[5:0]); // [R08] [R14]
			o_txfifo_wr <= cfg_wr && (addr_reg == ADDR_FIFO); // [R14]
			if (hdr_byte)
			begin
				o_strobe_addr <= link.rx_byte[5:0];
				o_ext_rd_addr <= link.rx_byte[5:0];
			end
			if (cfg_wr)
				o_txfifo_data <= link.rx_byte;
		end
	end

	// ==========================================================
	// configuration registers; nothing here reacts to sleep, so
	// contents survive it and only reset restores defaults
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			pin2_cfg_reg <= PIN2_CFG_RESET[6:0]; // [R02]
			pin1_cfg_reg <= PIN1_CFG_RESET;      // [R03]
			pin0_cfg_reg <= PIN0_CFG_RESET;      // [R04]
			thr_cfg_reg  <= THR_CFG_RESET;       // [R12]
		end
		else if (cfg_wr) // [R09]
		begin
			unique case (addr_reg)
				ADDR_PIN2_CFG: pin2_cfg_reg <= link.rx_byte[6:0]; // [R13]
				ADDR_PIN1_CFG: pin1_cfg_reg <= link.rx_byte;
				ADDR_PIN0_CFG: pin0_cfg_reg <= link.rx_byte;
				ADDR_THR_CFG:  thr_cfg_reg  <= link.rx_byte;
				default:       ;
			endcase
		end
	end

	// test registers reloaded on wake by the retention option
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			o_test_reg_one <= TEST_ONE_PLAIN;
			o_test_reg_two <= TEST_TWO_PLAIN;
		end
		else if (i_wake)
		begin
			o_test_reg_one <= thr_cfg_reg[RETENTION_BIT] ? TEST_ONE_RETAINED
				: TEST_ONE_PLAIN; // [R10]
			o_test_reg_two <= thr_cfg_reg[RETENTION_BIT] ? TEST_TWO_RETAINED
				: TEST_TWO_PLAIN; // [R10]
		end
	end

	// ==========================================================
	// pin and analog control outputs, one cycle behind settings
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			o_pin_out          <= 3'h0;
			o_pin_oe_n         <= 3'h7;
			o_pin_drive_strong <= 1'b0;
			o_temp_sensor_en   <= 1'b0;
			o_rx_atten         <= 2'h0;
			o_fifo_threshold   <= 4'h0;
			o_spi_miso         <= 1'b0;
			o_spi_miso_oe_n    <= 1'b1;
		end
		else
		begin
			o_pin_out[2]  <= pin_level({1'b0, pin2_cfg_reg}, i_sig_table); // [R01]
			o_pin_out[1]  <= pin_level(pin1_cfg_reg, i_sig_table);         // [R01]
			o_pin_out[0]  <= pin_level(pin0_cfg_reg, i_sig_table);         // [R01]
			o_pin_oe_n[2] <= (pin2_cfg_reg[5:0] == SELECT_HIGH_Z);
			o_pin_oe_n[1] <= (pin1_cfg_reg[5:0] == SELECT_HIGH_Z);          // [R03]
			o_pin_oe_n[0] <= (pin0_cfg_reg[5:0] == SELECT_HIGH_Z);
			o_pin_drive_strong <= pin1_cfg_reg[PIN_DRIVE_BIT];              // [R05]
			o_temp_sensor_en   <= pin0_cfg_reg[TEMP_SENSOR_BIT];            // [R06]
			o_rx_atten         <= thr_cfg_reg[ATTEN_LSB+1:ATTEN_LSB];       // [R12]
			o_fifo_threshold   <= thr_cfg_reg[3:0];
			o_spi_miso         <= link.miso_bit;
			o_spi_miso_oe_n    <= link.miso_oe_n;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	logic [5:0] sel0_prev;
	assign sel0_prev = pin0_cfg_reg[5:0];

	sequence hdr_write_strobe;
		hdr_byte && !link.rx_byte[HDR_READ_BIT] && in_strobe_range(link.rx_byte[5:0]);
	endsequence

	sequence wake_plain;
		i_wake && !thr_cfg_reg[RETENTION_BIT];
	endsequence

	sequence wake_kept;
		i_wake && thr_cfg_reg[RETENTION_BIT];
	endsequence

	pin_reset_a: assert property ($past(i_rst) |-> pin2_cfg_reg == 7'h29 // [R02]
		&& pin1_cfg_reg == 8'h2E && pin0_cfg_reg == 8'h3F)
		else $error("pin select reset values wrong");
	atten_reset_a: assert property ($past(i_rst) |-> thr_cfg_reg[5:4] == 2'h0) // [R12]
		else $error("attenuation field not zero after reset");
	pin_invert_a: assert property (!$past(i_rst) |->                      // [R01]
		o_pin_out[0] == ($past(i_sig_table[sel0_prev]) ^ $past(pin0_cfg_reg[6])))
		else $error("pin level does not follow select and invert");
	drive_shared_a: assert property (cfg_wr && addr_reg == ADDR_PIN1_CFG  // [R05]
		|=> ##1 o_pin_drive_strong == $past(link.rx_byte[7], 2))
		else $error("drive strength not taken from pin-1 bit 7");
	reserved_zero_a: assert property ((state_reg == ST_FETCH && addr_reg == 6'h00) // [R13]
		|=> !tx_byte_reg[7])
		else $error("pin-2 bit 7 read as one");
	strobe_pulse_a: assert property (hdr_write_strobe |=> o_strobe ##1 !o_strobe // [R08]
		&& state_reg == ST_HEADER)
		else $error("strobe address did not give a single strobe pulse");
	wake_load_a: assert property (wake_plain |=> o_test_reg_one == 8'h31  // [R10]
		&& o_test_reg_two == 8'h88)
		else $error("wake load without retention wrong");
	wake_retain_a: assert property (wake_kept |=> o_test_reg_one == 8'h35 // [R10]
		&& o_test_reg_two == 8'h81)
		else $error("wake load with retention wrong");
	sleep_keep_a: assert property (!cfg_wr |=> $stable(pin1_cfg_reg)      // [R09]
		&& $stable(pin0_cfg_reg) && $stable(thr_cfg_reg))
		else $error("configuration changed without a write");
	fifo_route_a: assert property (o_txfifo_wr |-> $past(addr_reg) == 6'h3F // [R14]
		&& !$past(read_reg))
		else $error("fifo write from wrong access");

endmodule : pin_signal_config_bank

// *** bench/host_spi_model.sv ***
// ==========================================================
// host side of the serial port, mode 0, msb first
module host_spi_model
(
	input  wire logic i_ref_clk,   // system clock
	input  wire logic i_miso,      // serial data from the bank
	input  wire logic i_miso_oe_n, // low while the bank drives
	output logic      o_sclk,      // serial clock, still outside frames
	output logic      o_cs_n,      // chip select, active low
	output logic      o_mosi       // serial data to the bank
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle levels at time zero
	initial
	begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
	end

	// open a frame; half periods kept at 4 clocks, one more than the shortest the bank allows
	task automatic start();
		@(posedge i_ref_clk);
		o_cs_n <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
	endtask : start

	// one whole byte each way, sampled just before sclk rises
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			o_mosi <= tx[i];
			repeat (4) @(posedge i_ref_clk);
			rx[i] = i_miso_oe_n ? ~i_miso : i_miso; // a released line reads inverted
			o_sclk <= 1'b1;
			repeat (4) @(posedge i_ref_clk);
			o_sclk <= 1'b0;
		end
	endtask : xfer

	// close the frame; released mosi flips so a stale bit cannot pass
	task automatic stop();
		repeat (4) @(posedge i_ref_clk);
		o_cs_n <= 1'b1;
		o_mosi <= ~o_mosi;
		repeat (8) @(posedge i_ref_clk);
	endtask : stop
endmodule : host_spi_model

// *** bench/tb.sv ***
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cfg_bank_pkg::*;

	// ==========================================================
	// signals
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        sclk, cs_n, mosi, miso, miso_oe_n;
	logic        wake = 1'b0;
	logic [7:0]  chip_status = 8'hA3;
	logic [63:0] sig_table = 64'h0000_0000_0000_0009;
	logic [7:0]  ext_rd_data;
	logic        ext_rd, strobe, tx_wr, drive_strong, temp_en;
	logic [5:0]  ext_rd_addr, strobe_addr;
	logic [7:0]  tx_data, test_one, test_two;
	logic [2:0]  pin_out, pin_oe_n;
	logic [1:0]  rx_atten;
	logic [3:0]  fifo_thr;
	int          fail_count = 0;
	int          n_compared = 0;
	int          n_strobe = 0;
	int          n_rd = 0;
	int          n_tx = 0;
	logic [7:0]  rx;

	always #5 ref_clk = ~ref_clk;

	// status and fifo answer derived from the address asked for
	assign ext_rd_data = {2'b10, ext_rd_addr};

	// pulse counters; the pulses last one cycle only
	always @(posedge ref_clk)
	begin
		n_strobe += (strobe === 1'b1);
		n_rd += (ext_rd === 1'b1);
		n_tx += (tx_wr === 1'b1);
	end

	host_spi_model u_host_spi_model (.i_ref_clk(ref_clk), .i_miso(miso),
		.i_miso_oe_n(miso_oe_n), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));

	pin_signal_config_bank u_pin_signal_config_bank (.i_ref_clk(ref_clk), .i_rst(rst),
		.i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_spi_miso(miso),
		.o_spi_miso_oe_n(miso_oe_n), .i_chip_status(chip_status), .i_sig_table(sig_table),
		.i_wake(wake), .i_ext_rd_data(ext_rd_data), .o_ext_rd(ext_rd),
		.o_ext_rd_addr(ext_rd_addr), .o_strobe(strobe), .o_strobe_addr(strobe_addr),
		.o_txfifo_wr(tx_wr), .o_txfifo_data(tx_data), .o_pin_out(pin_out),
		.o_pin_oe_n(pin_oe_n), .o_pin_drive_strong(drive_strong),
		.o_temp_sensor_en(temp_en), .o_rx_atten(rx_atten), .o_fifo_threshold(fifo_thr),
		.o_test_reg_one(test_one), .o_test_reg_two(test_two));

	// ==========================================================
	// shared tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	task automatic write1(input logic [7:0] hdr, input logic [7:0] data);
		u_host_spi_model.start();
		u_host_spi_model.xfer(hdr, rx);
		u_host_spi_model.xfer(data, rx);
		u_host_spi_model.stop();
	endtask : write1

	task automatic read1(input logic [7:0] hdr, output logic [7:0] data);
		u_host_spi_model.start();
		check(miso_oe_n, 8'h00);
		u_host_spi_model.xfer(hdr, rx);
		check(rx, chip_status);
		u_host_spi_model.xfer(8'h00, data);
		u_host_spi_model.stop();
	endtask : read1

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	// ==========================================================
	// scenarios
	task automatic check_reset();
		logic [7:0] d;
		// only pin 1 starts undriven: its select resets to the high-z code
		check({5'h00, pin_oe_n}, 8'h02);
		check({6'h00, rx_atten}, 8'h00);
		check({4'h0, fifo_thr}, THR_CFG_RESET[7:0] & 8'h0F);
		check(test_one, 8'h31);
		check(test_two, 8'h88);
		read1(8'h80, d);
		check(d, 8'h29);
		read1(8'h81, d);
		check(d, 8'h2E);
		read1(8'h82, d);
		check(d, 8'h3F);
	endtask : check_reset

	// burst from 0x00: reserved bit, invert, drive strength, sensor on
	task automatic pin_burst();
		logic [7:0] d;
		u_host_spi_model.start();
		u_host_spi_model.xfer(8'h40, rx);
		u_host_spi_model.xfer(8'hC5, rx);
		u_host_spi_model.xfer(8'hC3, rx);
		u_host_spi_model.xfer(8'h80, rx);       // clock output off, rest zero
		u_host_spi_model.stop();
		check({5'h00, pin_out}, 8'h05);
		check({5'h00, pin_oe_n}, 8'h00);
		check(drive_strong, 8'h01);
		check(temp_en, 8'h01);
		read1(8'h80, d);
		check(d, 8'h45);
	endtask : pin_burst

	task automatic strobes_status();
		logic [7:0] d;
		for (int a = 8'h30; a <= 8'h3D; a++)
		begin
			u_host_spi_model.start();
			u_host_spi_model.xfer(a[7:0], rx);
			u_host_spi_model.stop();
			check(n_strobe[7:0], a[7:0] - 8'h2F);
			check({2'b00, strobe_addr}, a[7:0]);
		end
		read1(8'hB5, d);
		check(d, 8'hB5);
		check(n_rd[7:0], 8'h01);
	endtask : strobes_status

	task automatic fifo_access();
		logic [7:0] d;
		u_host_spi_model.start();
		u_host_spi_model.xfer(8'h7F, rx);
		u_host_spi_model.xfer(8'hA5, rx);
		check(tx_data, 8'hA5);
		u_host_spi_model.xfer(8'h5A, rx);
		u_host_spi_model.stop();
		check(n_tx[7:0], 8'h02);
		check(tx_data, 8'h5A);
		read1(8'hBF, d);
		check(d, 8'hBF);
		check(n_strobe[7:0], 8'h0E);
	endtask : fifo_access

	task automatic pulse_wake();
		@(posedge ref_clk);
		wake <= 1'b1;
		@(posedge ref_clk);
		wake <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask : pulse_wake

	// reserved bit 7 kept zero by the host
	task automatic wake_loads();
		logic [7:0] d;
		write1(8'h03, 8'h67);
		check({6'h00, rx_atten}, 8'h02);
		pulse_wake();
		check(test_one, 8'h35);
		check(test_two, 8'h81);
		write1(8'h03, 8'h07);
		pulse_wake();
		check(test_one, 8'h31);
		check(test_two, 8'h88);
		read1(8'h80, d);
		check(d, 8'h45);
		check({5'h00, pin_out}, 8'h05);
	endtask : wake_loads

	task automatic unmapped();
		logic [7:0] d;
		write1(8'h10, 8'hFF);
		read1(8'h90, d);
		check(d, 8'h00);
	endtask : unmapped

	// ==========================================================
	// main sequence and hang guard
	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check_reset();
		pin_burst();
		strobes_status();
		fifo_access();
		wake_loads();
		unmapped();
		end_of_test();
	end

	initial
	begin
		repeat (90000) @(posedge ref_clk);
		fail_count++;
		end_of_test();
	end
endmodule : tb
